// file: rtl/fzio_pin.v
`timescale 1ns/1ps
`include "fzio_regs.vh"

module fzio_pin (
    input wire pclk,
    input wire presetn,
    input wire frozen,
    input wire freeze_entry,
    input wire cfg_hold,
    input wire cfg_pull_en,
    input wire cfg_pull_up,
    input wire core_out,
    input wire core_oe,
    input wire pad_in,
    output reg pad_out,
    output reg pad_oe,
    output reg pad_pull_en,
    output reg pad_pull_up,
    output reg core_in
);

    reg held_in_q;
    reg held_out_q;
    reg held_oe_q;

    // capture on the entry cycle, keep while frozen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_in_q <= 1'b1;
            held_out_q <= 1'b0;
            held_oe_q <= 1'b0;
        end else if (freeze_entry) begin
            held_in_q <= pad_in;
            held_out_q <= core_out;
            held_oe_q <= core_oe;
        end
        // pad activity while frozen is never sampled
    end

    always @* begin
        pad_out = core_out;
        pad_oe = core_oe;
        pad_pull_en = cfg_pull_en;
        pad_pull_up = cfg_pull_up;
        core_in = pad_in;
        if (frozen) begin
            pad_out = 1'b0;
            pad_oe = 1'b0;
            if (held_oe_q && cfg_hold) begin
                // output mode: weak pull to held level
                pad_pull_en = 1'b1;
                pad_pull_up = held_out_q;
                core_in = held_out_q;
            end else begin
                pad_pull_en = cfg_pull_en;
                pad_pull_up = cfg_pull_up & cfg_pull_en;
                if (cfg_hold) begin
                    core_in = held_in_q;
                end else begin
                    core_in = 1'b1;
                end
            end
        end
        // not frozen: pass-through
    end

endmodule

// file: rtl/fzio_regs.vh
`ifndef FZIO_REGS_VH
`define FZIO_REGS_VH

// register byte offsets
`define FZIO_OFF_CTRL 12'h000
`define FZIO_OFF_STATUS 12'h004
`define FZIO_OFF_HOLD 12'h008
`define FZIO_OFF_PULLEN 12'h00c
`define FZIO_OFF_PULLDIR 12'h010
`define FZIO_OFF_REJECT 12'h014

// control register fields
`define FZIO_CTRL_SWREQ 0
`define FZIO_CTRL_PINSEL_EN 1
`define FZIO_CTRL_PINSEL_LSB 8
`define FZIO_CTRL_PINSEL_W 5

// status register fields
`define FZIO_STAT_FROZEN 0
`define FZIO_STAT_REQPIN 1
`define FZIO_STAT_REJECT 2

// reset values
`define FZIO_RST_CTRL 32'h0000_0000
`define FZIO_RST_CFG 32'h0000_0000

// pad state encodings (normal drive, pull, tristate)
`define FZIO_PAD_NORMAL 2'h0
`define FZIO_PAD_PULL 2'h1
`define FZIO_PAD_TRI 2'h2

`endif

// file: rtl/fzio_top.v
`timescale 1ns/1ps
`include "fzio_regs.vh"

module fzio_top #(
    parameter NPINS = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire freeze_request_pin,
    input wire [NPINS-1:0] core_out,
    input wire [NPINS-1:0] core_oe,
    output wire [NPINS-1:0] core_in,
    input wire [NPINS-1:0] pad_in,
    output wire [NPINS-1:0] pad_out,
    output wire [NPINS-1:0] pad_oe,
    output wire [NPINS-1:0] pad_pull_en,
    output wire [NPINS-1:0] pad_pull_up,
    output wire frozen
);

    localparam ST_RUN = 2'b01;
    localparam ST_FRZ = 2'b10;

    reg [31:0] ctrl_q;
    reg [NPINS-1:0] hold_q;
    reg [NPINS-1:0] pull_en_q;
    reg [NPINS-1:0] pull_up_q;
    reg reject_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [31:0] rdata_d;
    reg addr_ok;

    wire wr_en = psel & penable & pwrite;
    wire req = freeze_request_pin | ctrl_q[`FZIO_CTRL_SWREQ];
    wire freeze_entry = (state_q == ST_RUN) & req;
    wire [`FZIO_CTRL_PINSEL_W-1:0] req_pin_idx =
        ctrl_q[`FZIO_CTRL_PINSEL_LSB +: `FZIO_CTRL_PINSEL_W];
    wire [NPINS-1:0] req_pin_mask =
        ctrl_q[`FZIO_CTRL_PINSEL_EN] ? ({{(NPINS-1){1'b0}}, 1'b1} << req_pin_idx)
                                     : {NPINS{1'b0}};
    wire [NPINS-1:0] pull_wr = pwdata[NPINS-1:0] & ~req_pin_mask;
    wire pull_bad = |(pwdata[NPINS-1:0] & req_pin_mask);

    // register write strobes, taken in the access phase
    wire wr_ctrl = wr_en & (paddr == `FZIO_OFF_CTRL);
    wire wr_hold = wr_en & (paddr == `FZIO_OFF_HOLD);
    wire wr_pull_en = wr_en & (paddr == `FZIO_OFF_PULLEN);
    wire wr_pull_dir = wr_en & (paddr == `FZIO_OFF_PULLDIR);
    wire wr_reject = wr_en & (paddr == `FZIO_OFF_REJECT) & pwdata[0];

    // index carried by a control write, checked against pulls already set
    wire [`FZIO_CTRL_PINSEL_W-1:0] new_pin_idx =
        pwdata[`FZIO_CTRL_PINSEL_LSB +: `FZIO_CTRL_PINSEL_W];
    wire [NPINS-1:0] new_pin_mask =
        pwdata[`FZIO_CTRL_PINSEL_EN] ? ({{(NPINS-1){1'b0}}, 1'b1} << new_pin_idx)
                                     : {NPINS{1'b0}};
    wire ctrl_bad = |(pull_en_q & new_pin_mask);

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign frozen = (state_q == ST_FRZ);

    // read data picked in the setup cycle; the clear register reads zero
    always @* begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            `FZIO_OFF_CTRL: begin
                rdata_d = ctrl_q;
            end
            `FZIO_OFF_STATUS: begin
                rdata_d[`FZIO_STAT_FROZEN] = frozen;
                rdata_d[`FZIO_STAT_REQPIN] = freeze_request_pin;
                rdata_d[`FZIO_STAT_REJECT] = reject_q;
            end
            `FZIO_OFF_HOLD: begin
                rdata_d[NPINS-1:0] = hold_q;
            end
            `FZIO_OFF_PULLEN: begin
                rdata_d[NPINS-1:0] = pull_en_q;
            end
            `FZIO_OFF_PULLDIR: begin
                rdata_d[NPINS-1:0] = pull_up_q;
            end
            `FZIO_OFF_REJECT: begin
                rdata_d = 32'h0000_0000;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rdata_d;
        end
    end

    // control register and per-pin static configuration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `FZIO_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= {NPINS{1'b0}};
        end else if (wr_hold) begin
            hold_q <= pwdata[NPINS-1:0];
        end
    end

    // a pull on the request pin is dropped whichever register comes last
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_en_q <= {NPINS{1'b0}};
        end else if (wr_pull_en) begin
            pull_en_q <= pull_wr;
        end else if (wr_ctrl) begin
            pull_en_q <= pull_en_q & ~new_pin_mask;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_q <= {NPINS{1'b0}};
        end else if (wr_pull_dir) begin
            pull_up_q <= pwdata[NPINS-1:0];
        end
    end

    // sticky reject flag: a new rejection beats a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_q <= 1'b0;
        end else if ((wr_pull_en & pull_bad) | (wr_ctrl & ctrl_bad)) begin
            reject_q <= 1'b1;
        end else if (wr_reject) begin
            reject_q <= 1'b0;
        end
    end

    // freeze state follows the request one cycle late
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (req) begin
                    state_d = ST_FRZ;
                end
            end
            ST_FRZ: begin
                if (!req) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // one slice per pad: capture, hold and pad override
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1) begin : g_pin
            fzio_pin u_pin (
                .pclk(pclk),
                .presetn(presetn),
                .frozen(frozen),
                .freeze_entry(freeze_entry),
                .cfg_hold(hold_q[i]),
                .cfg_pull_en(pull_en_q[i]),
                .cfg_pull_up(pull_up_q[i]),
                .core_out(core_out[i]),
                .core_oe(core_oe[i]),
                .pad_in(pad_in[i]),
                .pad_out(pad_out[i]),
                .pad_oe(pad_oe[i]),
                .pad_pull_en(pad_pull_en[i]),
                .pad_pull_up(pad_pull_up[i]),
                .core_in(core_in[i])
            );
        end
    endgenerate

endmodule

// file: sim/fzio_monitor.sv
`timescale 1ns/1ps
module fzio_monitor #(parameter NPINS = 16) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire freeze_request_pin,
    input wire [NPINS-1:0] core_out,
    input wire [NPINS-1:0] core_oe,
    input wire [NPINS-1:0] core_in,
    input wire [NPINS-1:0] pad_in,
    input wire [NPINS-1:0] pad_out,
    input wire [NPINS-1:0] pad_oe,
    input wire [NPINS-1:0] pad_pull_en,
    input wire frozen
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ask; freeze_request_pin && !frozen; endsequence
    sequence s_drop; frozen && !freeze_request_pin; endsequence
    property p_ent; s_ask |=> frozen; endproperty
    property p_rel; s_drop |=> !frozen; endproperty
    property p_cause; $rose(frozen) |-> $past(freeze_request_pin); endproperty
    property p_tri; frozen |-> pad_oe == 0; endproperty
    property p_held; frozen && $past(frozen) |-> $stable(core_in); endproperty
    property p_pass; !frozen |-> pad_oe == core_oe && pad_out == core_out
        && core_in == pad_in; endproperty
    property p_pcfg; !frozen && !$past(frozen) && !$past(psel && penable)
        |-> $stable(pad_pull_en); endproperty
    property p_err; pslverr |-> psel && penable; endproperty
    property p_rdy; psel && penable |-> pready; endproperty
    a_ent: assert property (p_ent) else $error("no freeze entry");
    a_rel: assert property (p_rel) else $error("no freeze release");
    a_cause: assert property (p_cause) else $error("freeze without request");
    a_tri: assert property (p_tri) else $error("pad driven in freeze");
    a_held: assert property (p_held) else $error("core input moved in freeze");
    a_pass: assert property (p_pass) else $error("no pass-through");
    a_pcfg: assert property (p_pcfg) else $error("pull moved without write");
    a_err: assert property (p_err) else $error("error outside access");
    a_rdy: assert property (p_rdy) else $error("ready low");
endmodule

bind fzio_top fzio_monitor #(.NPINS(NPINS)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .freeze_request_pin(freeze_request_pin), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .frozen(frozen));

// file: sim/tb.sv
`timescale 1ns/1ps
`include "fzio_regs.vh"
module tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic frz = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, frozen, e;
    logic [3:0] core_out = 4'h0;
    logic [3:0] core_oe = 4'h0;
    logic [3:0] pad_in = 4'h0;
    logic [3:0] core_in, pad_out, pad_oe, pull_en, pull_up;
    int miscompares = 0;
    int cmp_count = 0;
    fzio_top #(.NPINS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_request_pin(frz),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull_en),
        .pad_pull_up(pull_up), .frozen(frozen));
    initial forever #20 pclk = ~pclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task t_regs;
        apb(1'h0, `FZIO_OFF_PULLDIR, 32'h0);
        chk(r, 32'h0);
        apb(1'h1, `FZIO_OFF_PULLDIR, 32'hffff_ffff);
        apb(1'h0, `FZIO_OFF_PULLDIR, 32'h0);
        chk(r, 32'hf);
        apb(1'h0, 12'hff0, 32'h0);
        chk({r[30:0], e}, 32'h1);
    endtask
    task t_frz;
        apb(1'h1, `FZIO_OFF_HOLD, 32'h5);
        apb(1'h1, `FZIO_OFF_PULLEN, 32'h6);
        apb(1'h1, `FZIO_OFF_PULLDIR, 32'h2);
        core_oe <= 4'hc;
        core_out <= 4'hc;
        @(posedge pclk);
        frz <= 1'h1;
        repeat (2) @(posedge pclk);
        pad_in <= 4'hf;
        core_out <= 4'h3;
        core_oe <= 4'h3;
        repeat (3) @(posedge pclk);
        #1;
        chk({28'h0, core_in}, 32'he);
        chk({20'h0, pad_oe, pull_en, pull_up}, 32'h066);
        apb(1'h0, `FZIO_OFF_STATUS, 32'h0);
        chk(r & 32'h3, 32'h3);
        frz <= 1'h0;
        repeat (2) @(posedge pclk);
        #1;
        chk({16'h0, core_in, pad_oe, pad_out, pull_en}, 32'hf336);
    endtask
    task t_rej;
        apb(1'h1, `FZIO_OFF_CTRL, 32'h102);
        apb(1'h0, `FZIO_OFF_PULLEN, 32'h0);
        chk(r, 32'h4);
        apb(1'h1, `FZIO_OFF_REJECT, 32'h1);
        chk({31'h0, e}, 32'h0);
        apb(1'h1, `FZIO_OFF_PULLEN, 32'h3);
        apb(1'h0, `FZIO_OFF_PULLEN, 32'h0);
        chk(r, 32'h1);
        apb(1'h0, `FZIO_OFF_STATUS, 32'h0);
        chk(r & 32'h4, 32'h4);
        apb(1'h1, `FZIO_OFF_REJECT, 32'h1);
        apb(1'h0, `FZIO_OFF_STATUS, 32'h0);
        chk(r & 32'h4, 32'h0);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_frz;
        t_rej;
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge pclk);
        miscompares++;
        wrap_up;
    end
endmodule
